// [bench/apfs_far_side.sv]
// Far-side model: serial line engine and the pad loads of the aux pins.
`timescale 1ns/1ps
`default_nettype none

module apfs_far_side #(
    parameter BITS = 10
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Serial engine.
    input wire logic [15:0] bit_cyc,
    input wire logic [3:0] extra_bits,
    input wire logic tx_launch,
    output logic tx_busy,
    output logic tx_stop_done,
    // Pads.
    input wire logic [9:0] aux_pin_out,
    input wire logic [9:0] aux_pin_oe,
    input wire logic [9:0] aux_pin_pull_up,
    input wire logic [9:0] aux_pin_pull_down,
    output logic [9:0] aux_pin_in
);
    int cnt;
    logic flt = 1'h0;
    // Extra bits stretch the frame so a slow far side is exercised too.
    always @(posedge ref_clk) begin
        flt <= ~flt;
        tx_stop_done <= 1'h0;
        if (sys_rst) begin
            tx_busy <= 1'h0;
            cnt <= 0;
        end else if (tx_busy) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                tx_busy <= 1'h0;
                tx_stop_done <= 1'h1;
            end
        end else if (tx_launch) begin
            tx_busy <= 1'h1;
            cnt <= (BITS + extra_bits) * bit_cyc;
        end
    end
    // A floating pad toggles so that no stale level can pass for a real one.
    always @* begin
        for (int i = 0; i < 10; i++) begin
            aux_pin_in[i] = aux_pin_oe[i] ? aux_pin_out[i] : aux_pin_pull_up[i] ? 1'h1
                : aux_pin_pull_down[i] ? 1'h0 : flt;
        end
    end
endmodule

`default_nettype wire

// [bench/apfs_props.sv]
// Port checker of the aux pin selector, bound to its top module.
`timescale 1ns/1ps
`default_nettype none

module apfs_props #(
    parameter NPINS = 10
) (
    // Clock and reset.
    input wire ref_clk,
    input wire sys_rst,
    // Bus handshakes.
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Pins and sequencer.
    input wire tx_launch,
    input wire [NPINS-1:0] aux_pin_oe,
    input wire [NPINS-1:0] aux_pin_pull_up,
    input wire [NPINS-1:0] aux_pin_pull_down
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken before response");
    a_launch_single: assert property (tx_launch |=> !tx_launch)
        else $error("launch pulse longer than one cycle");
    a_pin_seven_inert: assert property (!aux_pin_oe[7])
        else $error("pin seven driven");
    a_pulls_apart: assert property ((aux_pin_pull_up & aux_pin_pull_down) == '0)
        else $error("pull-up and pull-down together");
    // Only this check stays armed through reset.
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !s_axi_bvalid && !s_axi_rvalid
        && aux_pin_oe == '0 && aux_pin_pull_up == '0)
        else $error("outputs active after reset");
endmodule

bind apfs_top apfs_props #(.NPINS(NPINS)) u_props (.*);

`default_nettype wire

// [bench/aux_pin_function_select_tb.sv]
// Self-checking bench of the aux pin selector against a reference model.
`timescale 1ns/1ps
`default_nettype none
`include "apfs_map.vh"

module aux_pin_function_select_tb;
    logic ref_clk = 1'h0, sys_rst = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, tx_char_req = 1'h0;
    logic usb_configured = 1'h0, usb_suspend = 1'h0, rx_busy = 1'h0, tb_txb = 1'h0;
    logic [9:0] aux_pin_in, aux_pin_out, aux_pin_oe, aux_pin_pull_up, aux_pin_pull_down;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_launch, tx_stop_done, far_busy;
    wire logic tx_busy = far_busy | tb_txb;
    int n_fail = 0, checks = 0, e, ne[5];
    int codes[11] = '{0, 2, 3, 4, 5, 6, 10, 11, 12, 13, 14};
    int cp[5] = '{0, 5, 6, 8, 9};
    logic [3:0] fc[10];
    logic [3:0] xb = 4'h0;
    logic [9:0] go = 10'h0, gd = 10'h0, pv;
    logic [15:0] dv = 16'h0364;
    logic ld = 1'h0, pdo = 1'h0;

    apfs_top dut (.*);
    apfs_far_side far (.ref_clk, .sys_rst, .bit_cyc(dv), .extra_bits(xb), .tx_launch,
        .tx_busy(far_busy), .tx_stop_done, .aux_pin_out, .aux_pin_oe, .aux_pin_pull_up,
        .aux_pin_pull_down, .aux_pin_in);

    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        checks++;
        if (g !== ex) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, ex, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic got = 1'h0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'($urandom_range(1));
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            got = s_axi_bvalid && s_axi_bready;
            s_axi_bready <= !got;
        end
        chk("bresp", {got, er}, {29'h0, 1'h1, s_axi_bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        logic got = 1'h0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'($urandom_range(1));
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            got = s_axi_rvalid && s_axi_rready;
            s_axi_rready <= !got;
        end
        chk("rdata", ex, s_axi_rdata);
        chk("rresp", {got, er}, {29'h0, 1'h1, s_axi_rresp});
    endtask
    // Expected pad state of pin p as {oe, out, pull_up, pull_down}.
    function automatic logic [3:0] mdl(int p);
        int k;
        logic s;
        k = ld ? fc[p] : (p == 7 ? 13 : 0);
        if (p == 7 && k != 13 || k >= 7 && k <= 10 && p > 0 && p < 5 || k == 12 && p < 5 || k > 13)
            k = 0;
        s = pdo && usb_suspend;
        case (k)
            0: return {2'h0, !s, s};
            2: return {1'h1, !(usb_configured && !usb_suspend), 2'h0};
            3: return {1'h1, !tx_busy, 2'h0};
            4: return {1'h1, !rx_busy, 2'h0};
            5: return {1'h1, !(tx_busy || rx_busy), 2'h0};
            6: return {1'h1, !usb_suspend, 2'h0};
            10: return 4'hC;
            11: return 4'h8;
            12: return gd[p] ? {1'h1, go[p], 2'h0} : {2'h0, !s, s};
            default: return 4'h1;
        endcase
    endfunction
    task automatic pins();
        repeat (4) @(posedge ref_clk);
        for (int p = 0; p < 10; p++) begin
            chk("pin", {p[7:0], mdl(p)}, {p[7:0], aux_pin_oe[p], aux_pin_oe[p] & aux_pin_out[p],
                aux_pin_pull_up[p], aux_pin_pull_down[p]});
        end
    endtask
    task automatic rstate();
        @(posedge ref_clk);
        usb_configured <= 1'($urandom_range(1));
        usb_suspend <= 1'($urandom_range(1));
        tb_txb <= 1'($urandom_range(1));
        rx_busy <= 1'($urandom_range(1));
        pins();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hA883));
        for (int i = 0; i < 10; i++) fc[i] = (i == 7) ? 4'hD : 4'h0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'h0;
        // Defaults hold until the configuration is marked as loaded.
        pins();
        rd(`APFS_REG_CTRL, 32'h0, `APFS_RESP_OKAY);
        rd(`APFS_REG_BIT_DIV, 32'h364, `APFS_RESP_OKAY);
        rd(`APFS_REG_GPIO_DIR, 32'h0, `APFS_RESP_OKAY);
        rd(`APFS_REG_FUNC_BASE + 8'h1C, 32'hD, `APFS_RESP_OKAY);
        rd(8'h18, 32'h0, `APFS_RESP_SLVERR);
        wr(8'h48, 32'hFFFF, `APFS_RESP_SLVERR);
        wr(`APFS_REG_STATUS, 32'h7, `APFS_RESP_OKAY);
        rd(`APFS_REG_STATUS, 32'h0, `APFS_RESP_OKAY);
        fc[0] = 4'hA;
        wr(`APFS_REG_FUNC_BASE, 32'hA, `APFS_RESP_OKAY);
        pins();
        rd(`APFS_REG_PIN_IN, 32'h37F, `APFS_RESP_OKAY);
        // Every static code on every pin under random USB and traffic state.
        ld = 1'h1;
        for (int p = 0; p < 10; p++) begin
            foreach (codes[j]) begin
                fc[p] = 4'(codes[j]);
                pdo = 1'($urandom_range(1));
                go = 10'($urandom);
                gd = 10'($urandom);
                wr(`APFS_REG_CTRL, {30'h0, pdo, 1'h1}, `APFS_RESP_OKAY);
                wr(`APFS_REG_GPIO_OUT, {22'h0, go}, `APFS_RESP_OKAY);
                wr(`APFS_REG_GPIO_DIR, {22'h0, gd}, `APFS_RESP_OKAY);
                wr(`APFS_REG_FUNC_BASE + 8'(4 * p), {28'h0, fc[p]}, `APFS_RESP_OKAY);
                repeat (2) rstate();
            end
        end
        // Divided clocks: rising edges over 200 cycles, none in suspend.
        foreach (cp[i]) wr(`APFS_REG_FUNC_BASE + 8'(4 * cp[i]), 7 + i % 3, `APFS_RESP_OKAY);
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk);
            usb_suspend <= s[0];
            repeat (4) @(posedge ref_clk);
            ne = '{default: 0};
            pv = aux_pin_out;
            repeat (200) begin
                @(posedge ref_clk);
                foreach (cp[i]) ne[i] += aux_pin_out[cp[i]] & !pv[cp[i]];
                pv = aux_pin_out;
            end
            foreach (cp[i]) begin
                e = s ? 0 : 60 >> (i % 3);
                chk("clk", 1, ne[i] >= e - 1 && ne[i] <= e + 1 && !(s && aux_pin_out[cp[i]]));
            end
        end
        // Driver enable: lead of one bit period, held through the frame, stray request ignored.
        usb_suspend <= 1'h0;
        tb_txb <= 1'h0;
        wr(`APFS_REG_FUNC_BASE, {28'h0, `APFS_FN_LINE_DRV_EN}, `APFS_RESP_OKAY);
        for (int i = 0; i < 2; i++) begin
            dv = i ? 16'h4 : 16'h1;
            xb = i ? 4'h3 : 4'h0;
            wr(`APFS_REG_BIT_DIV, {16'h0, dv}, `APFS_RESP_OKAY);
            tx_char_req <= 1'h1;
            @(posedge ref_clk);
            tx_char_req <= 1'h0;
            for (e = 0; e < 50 && !aux_pin_out[0]; e++) @(posedge ref_clk);
            for (e = 0; e < 50 && !tx_busy; e++) @(posedge ref_clk);
            chk("lead", {16'h0, dv}, e);
            ne = '{default: 0};
            tx_char_req <= 1'h1;
            for (e = 0; e < 300 && tx_busy; e++) begin
                @(posedge ref_clk);
                tx_char_req <= 1'h0;
                ne[0] += tx_launch;
                ne[1] += !aux_pin_out[0];
            end
            repeat (3) @(posedge ref_clk);
            chk("frame", 32'h0, {ne[0][7:0], ne[1][7:0], 15'h0, aux_pin_out[0]});
        end
        give_verdict();
    end
endmodule

`default_nettype wire

// [core/apfs_drv_enable.v]
// Transmit line driver enable sequencer with one bit period of lead time.
`timescale 1ns/1ps
`default_nettype none

module apfs_drv_enable #(
    parameter DIV_W = 16
) (
    // Clock and reset.
    input wire ref_clk,
    input wire sys_rst,
    // Bit period in clock cycles.
    input wire [DIV_W-1:0] bit_div,
    // Serial transmitter handshake.
    input wire tx_req,
    input wire tx_done,
    output reg tx_launch_q,
    // Driver enable level.
    output reg drv_en_q
);

localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_LEAD = 3'h2;
localparam [2:0] ST_SEND = 3'h4;

reg [2:0] state_q;
reg [DIV_W-1:0] cnt_q;

always @(posedge ref_clk) begin
    if (sys_rst) begin
        state_q <= ST_IDLE;
        cnt_q <= {DIV_W{1'b0}};
        tx_launch_q <= 1'b0;
        drv_en_q <= 1'b0;
    end else begin
        tx_launch_q <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (tx_req) begin
                    // The enable rises a full bit period before the start bit leaves.
                    drv_en_q <= 1'b1;
                    cnt_q <= bit_div;
                    state_q <= ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (cnt_q <= {{(DIV_W-1){1'b0}}, 1'b1}) begin
                    tx_launch_q <= 1'b1;
                    state_q <= ST_SEND;
                end else begin
                    cnt_q <= cnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
                end
            end
            ST_SEND: begin
                if (tx_done) begin
                    // Held until the transmitter reports the stop bit complete.
                    drv_en_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
            end
            default: begin
                drv_en_q <= 1'b0;
                state_q <= ST_IDLE;
            end
        endcase
    end
end

endmodule
`default_nettype wire

// [core/apfs_map.vh]
// Register map, field layout, function codes and timing constants of the aux pin selector.
`ifndef APFS_MAP_VH
`define APFS_MAP_VH

`define APFS_REG_CTRL 8'h00
`define APFS_REG_STATUS 8'h04
`define APFS_REG_BIT_DIV 8'h08
`define APFS_REG_GPIO_OUT 8'h0C
`define APFS_REG_GPIO_DIR 8'h10
`define APFS_REG_PIN_IN 8'h14
`define APFS_REG_FUNC_BASE 8'h20
`define APFS_REG_FUNC_LAST 8'h44

`define APFS_CTRL_CFG_LOADED 0
`define APFS_CTRL_SUSP_PD 1
`define APFS_STAT_CONFIGURED 0
`define APFS_STAT_SUSPEND 1
`define APFS_STAT_DRV_EN 2

`define APFS_CTRL_RST 2'h0
`define APFS_BIT_DIV_RST 16'h0364
`define APFS_GPIO_RST 10'h000
`define APFS_FUNC_RST 40'h00D0000000

`define APFS_FN_INPUT_PULLUP 4'h0
`define APFS_FN_LINE_DRV_EN 4'h1
`define APFS_FN_POWER_SWITCH_N 4'h2
`define APFS_FN_TX_LED_N 4'h3
`define APFS_FN_RX_LED_N 4'h4
`define APFS_FN_TRAFFIC_LED_N 4'h5
`define APFS_FN_SLEEP_N 4'h6
`define APFS_FN_CLK_FAST 4'h7
`define APFS_FN_CLK_HALF 4'h8
`define APFS_FN_CLK_QUARTER 4'h9
`define APFS_FN_DRIVE_HIGH 4'hA
`define APFS_FN_DRIVE_LOW 4'hB
`define APFS_FN_GPIO 4'hC
`define APFS_FN_INPUT_PULLDOWN 4'hD

`define APFS_PINS_COMMON 10'h37F
`define APFS_PINS_CLOCK 10'h361
`define APFS_PINS_GPIO 10'h360

`define APFS_REF_CLK_KHZ 100000
`define APFS_CLK_FAST_KHZ 30000
`define APFS_CLK_HALF_KHZ 15000
`define APFS_CLK_QUARTER_KHZ 7500
`define APFS_NCO_SCALE 65536

`define APFS_RESP_OKAY 2'h0
`define APFS_RESP_SLVERR 2'h2

`endif

// [core/apfs_top.v]
// Auxiliary pin function selector with an AXI4-Lite register port.
//
// Behaviour
// - Pins follow configured function, default input pull-up.
// - Pin seven defaults to input pull-down.
// - Driver enable leads start bit, holds past stop.
// - Power switch low when configured, high suspended.
// - Transmit LED pulses low while sending.
// - Receive LED pulses low while receiving.
// - Traffic LED pulses low on either direction.
// - Sleep output low throughout USB suspend.
// - Clock outputs on pins 0,5,6,8,9; stop suspended.
// - Bit-bang GPIO only on pins 5,6,8,9.
// - Inputs pulled up; optional pull-down in suspend.
`timescale 1ns/1ps
`default_nettype none
`include "apfs_map.vh"

module apfs_top #(
    parameter ADDR_W = 8,
    parameter NPINS = 10,
    parameter DIV_W = 16
) (
    // Clock and reset.
    input wire ref_clk,
    input wire sys_rst,
    // AXI4-Lite write address channel.
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data channel.
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response channel.
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address channel.
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data channel.
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // USB device state.
    input wire usb_configured,
    input wire usb_suspend,
    // Serial engine activity.
    input wire tx_char_req,
    input wire tx_stop_done,
    input wire tx_busy,
    input wire rx_busy,
    output wire tx_launch,
    // Auxiliary pads.
    input wire [NPINS-1:0] aux_pin_in,
    output reg [NPINS-1:0] aux_pin_out,
    output reg [NPINS-1:0] aux_pin_oe,
    output reg [NPINS-1:0] aux_pin_pull_up,
    output reg [NPINS-1:0] aux_pin_pull_down
);

////////////////////////////////////////////////////////////////////////////////

localparam integer STEP_FAST_I = (`APFS_CLK_FAST_KHZ * `APFS_NCO_SCALE) / `APFS_REF_CLK_KHZ;
localparam integer STEP_HALF_I = (`APFS_CLK_HALF_KHZ * `APFS_NCO_SCALE) / `APFS_REF_CLK_KHZ;
localparam integer STEP_QTR_I = (`APFS_CLK_QUARTER_KHZ * `APFS_NCO_SCALE) / `APFS_REF_CLK_KHZ;
localparam [15:0] STEP_FAST = STEP_FAST_I[15:0];
localparam [15:0] STEP_HALF = STEP_HALF_I[15:0];
localparam [15:0] STEP_QTR = STEP_QTR_I[15:0];
localparam [4*NPINS-1:0] FUNC_RST = `APFS_FUNC_RST;
localparam [NPINS-1:0] PINS_COMMON = `APFS_PINS_COMMON;
localparam [NPINS-1:0] PINS_CLOCK = `APFS_PINS_CLOCK;
localparam [NPINS-1:0] PINS_GPIO = `APFS_PINS_GPIO;

reg [1:0] ctrl_q;
reg [DIV_W-1:0] bit_div_q;
reg [NPINS-1:0] gpio_out_q;
reg [NPINS-1:0] gpio_dir_q;
reg [4*NPINS-1:0] func_q;
reg [NPINS-1:0] pin_meta_q;
reg [NPINS-1:0] pin_sync_q;
reg [15:0] acc_fast_q;
reg [15:0] acc_half_q;
reg [15:0] acc_qtr_q;
reg [ADDR_W-1:0] aw_addr_q;
reg aw_got_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;
reg w_got_q;
reg [31:0] rd_mux;
reg rd_hit;
wire drv_en;
wire [4*NPINS-1:0] pin_next;
wire cfg_loaded = ctrl_q[`APFS_CTRL_CFG_LOADED];
wire susp_pd_en = ctrl_q[`APFS_CTRL_SUSP_PD];
wire do_write = aw_got_q & w_got_q & ~s_axi_bvalid;

////////////////////////////////////////////////////////////////////////////////

// Merge byte lanes of a write into a 16-bit field.
function [15:0] merge16;
    input [15:0] old_v;
    input [31:0] data;
    input [3:0] strb;
    begin
        merge16[7:0] = strb[0] ? data[7:0] : old_v[7:0];
        merge16[15:8] = strb[1] ? data[15:8] : old_v[15:8];
    end
endfunction

// Whether a function code may be used on a pin with the given availability bits.
function allowed;
    input [3:0] code;
    input common;
    input clock;
    input gpio;
    begin
        case (code)
            `APFS_FN_INPUT_PULLUP, `APFS_FN_INPUT_PULLDOWN: allowed = 1'b1;
            `APFS_FN_CLK_FAST, `APFS_FN_CLK_HALF, `APFS_FN_CLK_QUARTER,
            `APFS_FN_DRIVE_HIGH: allowed = clock;
            `APFS_FN_GPIO: allowed = gpio;
            default: allowed = common & (code <= `APFS_FN_DRIVE_LOW);
        endcase
    end
endfunction

// Pad drive for one pin as {oe, out, pull_up, pull_down}.
function [3:0] pin_drive;
    input [3:0] code;
    input gpio_out;
    input gpio_dir;
    input suspend;
    input configured;
    input pd_opt;
    input drv;
    input txb;
    input rxb;
    input ck_fast;
    input ck_half;
    input ck_qtr;
    reg in_pu;
    reg in_pd;
    begin
        // Input pulls flip to a gentle pull-down in suspend when the option is set.
        in_pd = pd_opt & suspend;
        in_pu = ~in_pd;
        case (code)
            `APFS_FN_LINE_DRV_EN: pin_drive = {1'b1, drv, 2'b00};
            `APFS_FN_POWER_SWITCH_N: pin_drive = {1'b1, ~(configured & ~suspend), 2'b00};
            `APFS_FN_TX_LED_N: pin_drive = {1'b1, ~txb, 2'b00};
            `APFS_FN_RX_LED_N: pin_drive = {1'b1, ~rxb, 2'b00};
            `APFS_FN_TRAFFIC_LED_N: pin_drive = {1'b1, ~(txb | rxb), 2'b00};
            `APFS_FN_SLEEP_N: pin_drive = {1'b1, ~suspend, 2'b00};
            `APFS_FN_CLK_FAST: pin_drive = {1'b1, ck_fast, 2'b00};
            `APFS_FN_CLK_HALF: pin_drive = {1'b1, ck_half, 2'b00};
            `APFS_FN_CLK_QUARTER: pin_drive = {1'b1, ck_qtr, 2'b00};
            `APFS_FN_DRIVE_HIGH: pin_drive = 4'hC;
            `APFS_FN_DRIVE_LOW: pin_drive = 4'h8;
            `APFS_FN_GPIO: begin
                if (gpio_dir) begin
                    pin_drive = {1'b1, gpio_out, 2'b00};
                end else begin
                    pin_drive = {2'b00, in_pu, in_pd};
                end
            end
            `APFS_FN_INPUT_PULLDOWN: pin_drive = 4'h1;
            default: pin_drive = {2'b00, in_pu, in_pd};
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

wire [15:0] gpio_out_m = merge16({6'h00, gpio_out_q}, w_data_q, w_strb_q);
wire [15:0] gpio_dir_m = merge16({6'h00, gpio_dir_q}, w_data_q, w_strb_q);
genvar gi;
generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
        wire [3:0] stored;
        wire [3:0] chosen;
        wire [3:0] code;
        wire [3:0] dflt;
        // Without loaded configuration memory the reset defaults stand in.
        assign dflt = FUNC_RST[4*gi +: 4];
        assign stored = func_q[4*gi +: 4];
        assign chosen = cfg_loaded ? stored : dflt;
        // An option the pin cannot carry falls back to a pulled-up input.
        assign code = allowed(chosen, PINS_COMMON[gi], PINS_CLOCK[gi],
            PINS_GPIO[gi]) ? chosen : `APFS_FN_INPUT_PULLUP;
        assign pin_next[4*gi +: 4] = pin_drive(code, gpio_out_q[gi], gpio_dir_q[gi],
            usb_suspend, usb_configured, susp_pd_en, drv_en, tx_busy, rx_busy,
            acc_fast_q[15], acc_half_q[15], acc_qtr_q[15]);
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////

apfs_drv_enable #(
    .DIV_W(DIV_W)
) u_drv_enable (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .bit_div(bit_div_q),
    .tx_req(tx_char_req),
    .tx_done(tx_stop_done),
    .tx_launch_q(tx_launch),
    .drv_en_q(drv_en)
);

// The clocks come from phase accumulators on the reference clock, so their
// edges jitter by one reference period; average frequency is exact enough for
// LED or logic use but not for a jitter-sensitive clock input.
always @(posedge ref_clk) begin
    if (sys_rst || usb_suspend) begin
        acc_fast_q <= 16'h0000;
        acc_half_q <= 16'h0000;
        acc_qtr_q <= 16'h0000;
    end else begin
        acc_fast_q <= acc_fast_q + STEP_FAST;
        acc_half_q <= acc_half_q + STEP_HALF;
        acc_qtr_q <= acc_qtr_q + STEP_QTR;
    end
end

integer k;
always @(posedge ref_clk) begin
    if (sys_rst) begin
        aux_pin_oe <= {NPINS{1'b0}};
        aux_pin_out <= {NPINS{1'b0}};
        aux_pin_pull_up <= {NPINS{1'b0}};
        aux_pin_pull_down <= {NPINS{1'b0}};
        pin_meta_q <= {NPINS{1'b0}};
        pin_sync_q <= {NPINS{1'b0}};
    end else begin
        for (k = 0; k < NPINS; k = k + 1) begin
            aux_pin_oe[k] <= pin_next[4*k+3];
            aux_pin_out[k] <= pin_next[4*k+2];
            aux_pin_pull_up[k] <= pin_next[4*k+1];
            aux_pin_pull_down[k] <= pin_next[4*k];
        end
        pin_meta_q <= aux_pin_in;
        pin_sync_q <= pin_meta_q;
    end
end

////////////////////////////////////////////////////////////////////////////////

integer m;
always @(posedge ref_clk) begin
    if (sys_rst) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `APFS_RESP_OKAY;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        aw_addr_q <= {ADDR_W{1'b0}};
        w_data_q <= 32'h00000000;
        w_strb_q <= 4'h0;
        ctrl_q <= `APFS_CTRL_RST;
        bit_div_q <= `APFS_BIT_DIV_RST;
        gpio_out_q <= `APFS_GPIO_RST;
        gpio_dir_q <= `APFS_GPIO_RST;
        func_q <= `APFS_FUNC_RST;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            aw_got_q <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_got_q <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (do_write) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `APFS_RESP_OKAY;
            case (aw_addr_q)
                `APFS_REG_CTRL: ctrl_q <= w_strb_q[0] ? w_data_q[1:0] : ctrl_q;
                `APFS_REG_BIT_DIV: bit_div_q <= merge16(bit_div_q, w_data_q, w_strb_q);
                `APFS_REG_GPIO_OUT: gpio_out_q <= gpio_out_m[NPINS-1:0];
                `APFS_REG_GPIO_DIR: gpio_dir_q <= gpio_dir_m[NPINS-1:0];
                `APFS_REG_STATUS, `APFS_REG_PIN_IN: s_axi_bresp <= `APFS_RESP_OKAY;
                default: begin
                    s_axi_bresp <= `APFS_RESP_SLVERR;
                    for (m = 0; m < NPINS; m = m + 1) begin
                        if (aw_addr_q == `APFS_REG_FUNC_BASE + 4 * m) begin
                            s_axi_bresp <= `APFS_RESP_OKAY;
                            func_q[4*m +: 4] <= w_strb_q[0] ? w_data_q[3:0] : func_q[4*m +: 4];
                        end
                    end
                end
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

integer n;
always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
        `APFS_REG_CTRL: rd_mux[1:0] = ctrl_q;
        `APFS_REG_STATUS: begin
            rd_mux[`APFS_STAT_CONFIGURED] = usb_configured;
            rd_mux[`APFS_STAT_SUSPEND] = usb_suspend;
            rd_mux[`APFS_STAT_DRV_EN] = drv_en;
        end
        `APFS_REG_BIT_DIV: rd_mux[DIV_W-1:0] = bit_div_q;
        `APFS_REG_GPIO_OUT: rd_mux[NPINS-1:0] = gpio_out_q;
        `APFS_REG_GPIO_DIR: rd_mux[NPINS-1:0] = gpio_dir_q;
        `APFS_REG_PIN_IN: rd_mux[NPINS-1:0] = pin_sync_q;
        default: begin
            rd_hit = 1'b0;
            for (n = 0; n < NPINS; n = n + 1) begin
                if (s_axi_araddr == `APFS_REG_FUNC_BASE + 4 * n) begin
                    rd_hit = 1'b1;
                    rd_mux[3:0] = func_q[4*n +: 4];
                end
            end
        end
    endcase
end

always @(posedge ref_clk) begin
    if (sys_rst) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `APFS_RESP_OKAY;
    end else begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `APFS_RESP_OKAY : `APFS_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule
`default_nettype wire
